// ==== wlie_exec.sv ====
// Purpose: Executes the word-load group against the data cache.
// Assumes: Register file reads are combinational on the select outputs.
// Notes: One load in flight; the string load only gets its fault tail.
`timescale 1ns/1ps
module wlie_exec
  import wlie_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr,
  output logic instr_ready,
  output logic [SEL_W-1:0] base_read_sel,
  output logic [SEL_W-1:0] index_read_sel,
  input wire logic [WORD_W-1:0] base_value,
  input wire logic [WORD_W-1:0] index_value,
  input wire logic [TBC_W-1:0] string_byte_count,
  input wire logic user_mode,
  input wire logic data_xlate_en,
  input wire logic reservation_clear,
  output logic mem_req,
  output logic [WORD_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_tlb_miss,
  input wire logic mem_zone_deny,
  input wire logic mem_bus_err,
  output logic dest_we,
  output logic [SEL_W-1:0] dest_sel,
  output logic [WORD_W-1:0] dest_data,
  output logic base_we,
  output logic [SEL_W-1:0] base_sel,
  output logic [WORD_W-1:0] base_data,
  output logic reservation,
  output logic string_drop_base,
  output logic exc_align,
  output logic exc_storage,
  output logic exc_tlb_miss,
  output logic exc_mcheck,
  output logic done
);

  // ==========================================================
  // Helpers

  // Base plus offset, wrapping at the word width.
  function automatic logic [WORD_W-1:0] ea_sum(
    input logic [WORD_W-1:0] b,
    input logic [WORD_W-1:0] o
  );
    ea_sum = b + o;
  endfunction

  // Memory byte 0 sits in bits 31:24 of the bus word.
  function automatic logic [WORD_W-1:0] byte_rev(
    input logic [WORD_W-1:0] w
  );
    byte_rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // ==========================================================
  // Decode

  wlie_dec_if dec ();
  assign dec.instr = instr;

  wlie_decode u_decode (
    .dec(dec)
  );

  // ==========================================================
  // Address formation

  wlie_state_e state;
  wlie_state_e next_state;
  logic [WORD_W-1:0] base_pick;
  logic [WORD_W-1:0] offset_pick;
  logic [WORD_W-1:0] effective_address;
  logic take;
  logic misaligned;

  // Register file selects follow the raw instruction directly.
  assign base_read_sel = dec.base_register_field;
  assign index_read_sel = dec.index_register_field;

  // Zero base only for the non-update forms.
  assign base_pick = dec.base_zero ? WORD_RST : base_value;
  // Index register or sign-extended displacement.
  assign offset_pick = dec.indexed ? index_value : dec.disp_ext;
  assign effective_address = ea_sum(base_pick, offset_pick);

  assign instr_ready = (state == ST_IDLE);
  assign take = instr_valid && instr_ready;
  // Only the reserving load checks word alignment.
  assign misaligned = (dec.op == OP_RESERVE) &&
                      (effective_address[1:0] != 2'b00);

  // ==========================================================
  // Sequencer: an unaligned reserving load and unknown opcodes never
  // reach the cache, so a faulting access is not half started.

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && dec.op != OP_NONE && !misaligned) begin
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (mem_ack) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign mem_req = (state == ST_ACCESS);

  // ==========================================================
  // Captured operation context.

  wlie_op_e op_q;
  logic [TBC_W-1:0] tbc_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= OP_NONE;
      tbc_q <= '0;
      mem_addr <= WORD_RST;
      dest_sel <= SEL_RST;
      base_sel <= SEL_RST;
    end else if (take) begin
      op_q <= dec.op;
      tbc_q <= string_byte_count;
      mem_addr <= effective_address;
      dest_sel <= dec.dest_sel;
      base_sel <= dec.base_register_field;
    end
  end

  // String base overlap: the base lies among the destination registers
  // that the byte count would fill, wrapping past register 31. The
  // string mover uses this to drop those bytes; no trap follows.
  logic [SEL_W-1:0] str_dist;
  logic [TBC_W:0] str_sum;
  logic [TBC_W-1:0] str_regs;

  always_comb begin
    str_dist = dec.base_register_field - dec.dest_sel;
    // A spare top bit keeps counts near the maximum from wrapping to zero.
    str_sum = {1'b0, string_byte_count} + 8'h03;
    str_regs = {1'b0, str_sum[TBC_W:2]};
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      string_drop_base <= 1'b0;
    end else if (take) begin
      string_drop_base <= (dec.op == OP_STRING) &&
                          ({2'b00, str_dist} < str_regs);
    end
  end

  // ==========================================================
  // Fault selection at the cache answer. A TLB miss outranks zone
  // denial, which outranks a bus error, so one fault is reported.

  logic ack_now;
  logic str_zero;
  logic f_tlb;
  logic f_zone;
  logic f_bus;
  logic fault;

  assign ack_now = mem_req && mem_ack;
  assign str_zero = (op_q == OP_STRING) && (tbc_q == '0);

  always_comb begin
    // Translation faults are suppressed for an empty string.
    f_tlb = data_xlate_en && mem_tlb_miss && !str_zero;
    f_zone = user_mode && data_xlate_en && mem_zone_deny &&
             !str_zero && !f_tlb;
    // A fill bus error still traps, even for an empty string.
    f_bus = mem_bus_err && !f_tlb && !f_zone;
    fault = f_tlb || f_zone || f_bus;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      exc_align <= 1'b0;
      exc_storage <= 1'b0;
      exc_tlb_miss <= 1'b0;
      exc_mcheck <= 1'b0;
      done <= 1'b0;
    end else begin
      exc_align <= take && misaligned;
      exc_storage <= ack_now && f_zone;
      exc_tlb_miss <= ack_now && f_tlb;
      exc_mcheck <= ack_now && f_bus;
      done <= ack_now || (take && (misaligned || dec.op == OP_NONE));
    end
  end

  // ==========================================================
  // Write-back. The string load never writes here; its byte moves
  // belong to the string sequencer, so an empty count writes nothing here either.
  // Update forms with base equal to destination or zero write both
  // ports anyway; the register file outcome is left undefined.

  logic load_ok;
  assign load_ok = ack_now && !fault && (op_q != OP_STRING);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dest_we <= 1'b0;
      dest_data <= WORD_RST;
    end else begin
      dest_we <= load_ok;
      if (load_ok) begin
        if (op_q == OP_BYTE_REV) begin
          dest_data <= byte_rev(mem_rdata);
        end else begin
          dest_data <= mem_rdata;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      base_we <= 1'b0;
      base_data <= WORD_RST;
    end else begin
      // No check of base against destination or zero.
      base_we <= load_ok && (op_q == OP_LOAD_UPD ||
                             op_q == OP_INDEXED_UPD);
      base_data <= mem_addr;
    end
  end

  // ==========================================================
  // Reservation bit: a completed reserving load sets it. Set wins
  // over a clear arriving in the same cycle, so the pairing store in
  // the software retry loop sees the newest reservation.

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reservation <= RESERVE_RST;
    end else if (load_ok && op_q == OP_RESERVE) begin
      reservation <= 1'b1;
    end else if (reservation_clear) begin
      reservation <= 1'b0;
    end
  end

  // ==========================================================
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_align_fault: assert property (
    take && dec.op == OP_RESERVE && effective_address[1:0] != 2'b00
    |=> exc_align && !mem_req && done && !dest_we)
    else $error("unaligned reserving load not faulted");

  a_reserve_decode: assert property (
    take && instr[31:26] == 6'h1F && instr[10:1] == 10'h014
    && effective_address[1:0] == 2'b00 |=> mem_req && op_q == OP_RESERVE)
    else $error("reserving load not decoded");

  a_reserve_set: assert property (
    ack_now && !fault && op_q == OP_RESERVE
    |=> reservation && dest_we && dest_data == $past(mem_rdata))
    else $error("reservation not set after reserving load");

  a_byte_order: assert property (
    ack_now && !fault && op_q == OP_BYTE_REV
    |=> dest_data[7:0] == $past(mem_rdata[31:24])
        && dest_data[31:24] == $past(mem_rdata[7:0])
        && dest_data[15:8] == $past(mem_rdata[23:16]))
    else $error("byte-reversed load order wrong");

  a_disp_addr: assert property (
    take && instr[31:26] == 6'h20 && instr[20:16] != 5'h00
    |=> mem_addr == $past(base_value)
        + {{16{$past(instr[15])}}, $past(instr[15:0])})
    else $error("displacement address wrong");

  a_upd_base: assert property (
    take && instr[31:26] == 6'h21
    |=> mem_addr == $past(base_value)
        + {{16{$past(instr[15])}}, $past(instr[15:0])})
    else $error("update load did not use base register");

  a_upd_write: assert property (
    ack_now && !fault && op_q == OP_INDEXED_UPD
    |=> base_we && base_data == $past(mem_addr) && dest_we)
    else $error("indexed update did not write address back");

  a_zero_base: assert property (
    take && instr[31:26] == 6'h1F && instr[10:1] == 10'h017
    && instr[20:16] == 5'h00 |=> mem_addr == $past(index_value))
    else $error("zero base field not treated as zero");

  a_empty_quiet: assert property (
    ack_now && op_q == OP_STRING && tbc_q == 7'h00
    |=> !exc_storage && !exc_tlb_miss && !dest_we)
    else $error("empty string load raised translation fault");

  a_empty_mcheck: assert property (
    ack_now && op_q == OP_STRING && tbc_q == 7'h00 && mem_bus_err
    |=> exc_mcheck)
    else $error("empty string load lost machine check");

  a_tlb_miss: assert property (
    ack_now && data_xlate_en && mem_tlb_miss && op_q != OP_STRING
    |=> exc_tlb_miss && !dest_we ##1 !exc_tlb_miss)
    else $error("TLB miss not reported once");

  a_zone_deny: assert property (
    ack_now && !(user_mode && data_xlate_en) && !mem_tlb_miss
    && !mem_bus_err |=> !exc_storage && (dest_we || op_q == OP_STRING))
    else $error("storage fault outside user translated mode");

  c_reserve_done: cover property (
    ack_now && op_q == OP_RESERVE ##1 reservation);
  c_update_load: cover property (ack_now && op_q == OP_LOAD_UPD);
  c_empty_string: cover property (
    ack_now && op_q == OP_STRING && tbc_q == 7'h00);
  c_back_to_back: cover property (done ##1 take);

endmodule

// ==== wlie_pkg.sv ====
// Purpose: Shared constants and types of the word-load execute block.
// Assumes: Instruction and data words are 32 bits, big-endian numbered.
// Notes: Field positions are little-endian indices of the bus vectors.
package wlie_pkg;

  // ==========================================================
  // Widths
  localparam int WORD_W = 32;
  localparam int SEL_W = 5;
  localparam int TBC_W = 7;
  localparam int DISP_W = 16;
  localparam int XO_W = 10;
  localparam int PRI_W = 6;

  // ==========================================================
  // Instruction field positions (lowest bit of each field).
  localparam int POS_PRI = 26;
  localparam int POS_RD = 21;
  localparam int POS_RA = 16;
  localparam int POS_RB = 11;
  localparam int POS_XO = 1;
  localparam int POS_DISP = 0;

  // ==========================================================
  // Primary and extended opcodes.
  localparam logic [PRI_W-1:0] PRI_XFORM = 6'h1F;
  localparam logic [PRI_W-1:0] PRI_LOAD = 6'h20;
  localparam logic [PRI_W-1:0] PRI_LOAD_UPD = 6'h21;
  localparam logic [XO_W-1:0] XO_RESERVE = 10'h014;
  localparam logic [XO_W-1:0] XO_INDEXED = 10'h017;
  localparam logic [XO_W-1:0] XO_INDEXED_UPD = 10'h037;
  localparam logic [XO_W-1:0] XO_STRING = 10'h215;
  localparam logic [XO_W-1:0] XO_BYTE_REV = 10'h216;

  // ==========================================================
  // Reset values.
  localparam logic RESERVE_RST = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;

  // ==========================================================
  // Decoded operations and sequencer states.
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_RESERVE = 3'h1,
    OP_BYTE_REV = 3'h2,
    OP_LOAD = 3'h3,
    OP_LOAD_UPD = 3'h4,
    OP_INDEXED_UPD = 3'h5,
    OP_INDEXED = 3'h6,
    OP_STRING = 3'h7
  } wlie_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01
  } wlie_state_e;

endpackage

// ==== wlie_dec_if.sv ====
// Purpose: Carries a raw instruction and its decoded fields.
// Assumes: Decoder is purely combinational.
// Notes: The execute unit drives the word, the decoder the fields.
`timescale 1ns/1ps
interface wlie_dec_if;
  import wlie_pkg::*;

  // ==========================================================
  // Decoded instruction bundle.
  logic [WORD_W-1:0] instr;
  wlie_op_e op;
  logic [SEL_W-1:0] dest_sel;
  logic [SEL_W-1:0] base_register_field;
  logic [SEL_W-1:0] index_register_field;
  logic [WORD_W-1:0] disp_ext;
  logic base_zero;
  logic indexed;
  logic update;

  modport decoder (
    input instr,
    output op, dest_sel, base_register_field, index_register_field,
    output disp_ext, base_zero, indexed, update
  );
  modport exec (
    output instr,
    input op, dest_sel, base_register_field, index_register_field,
    input disp_ext, base_zero, indexed, update
  );
endinterface

// ==== wlie_decode.sv ====
// Purpose: Decodes the word-load group from a 32-bit instruction.
// Assumes: Bit 0 of the architecture is vector bit 31.
// Notes: Reserved bits are never inspected, so they cannot trap.
`timescale 1ns/1ps
module wlie_decode
  import wlie_pkg::*;
(
  wlie_dec_if.decoder dec
);

  logic [PRI_W-1:0] pri;
  logic [XO_W-1:0] xo;

  // ==========================================================
  // Field extraction.
  assign pri = dec.instr[POS_PRI +: PRI_W];
  assign xo = dec.instr[POS_XO +: XO_W];
  assign dec.dest_sel = dec.instr[POS_RD +: SEL_W];
  assign dec.base_register_field = dec.instr[POS_RA +: SEL_W];
  assign dec.index_register_field = dec.instr[POS_RB +: SEL_W];
  // Sign-extend the displacement to a full word.
  assign dec.disp_ext = {{(WORD_W-DISP_W){dec.instr[DISP_W-1]}},
                         dec.instr[POS_DISP +: DISP_W]};

  // Opcode match; the low reserved bit is left out on purpose.
  always_comb begin
    dec.op = OP_NONE;
    if (pri == PRI_LOAD) begin
      dec.op = OP_LOAD;
    end else if (pri == PRI_LOAD_UPD) begin
      dec.op = OP_LOAD_UPD;
    end else if (pri == PRI_XFORM) begin
      case (xo)
        XO_RESERVE: dec.op = OP_RESERVE;
        XO_BYTE_REV: dec.op = OP_BYTE_REV;
        XO_INDEXED_UPD: dec.op = OP_INDEXED_UPD;
        XO_INDEXED: dec.op = OP_INDEXED;
        XO_STRING: dec.op = OP_STRING;
        default: dec.op = OP_NONE;
      endcase
    end
  end

  // Addressing form flags.
  always_comb begin
    dec.indexed = (dec.op != OP_LOAD) && (dec.op != OP_LOAD_UPD);
    dec.update = (dec.op == OP_LOAD_UPD) || (dec.op == OP_INDEXED_UPD);
    // Update forms read the base register even when its field is zero.
    dec.base_zero = !dec.update &&
                    (dec.base_register_field == SEL_RST);
  end

endmodule

// ==== wlie_cache_model.sv ====
// Purpose: Behavioural data cache that answers word loads.
// Assumes: One access at a time, request held until acknowledged.
// Notes: Fault flags come from the bench; data is the address xor PATTERN.
`timescale 1ns/1ps
module wlie_cache_model
  import wlie_pkg::*;
#(
  parameter logic [WORD_W-1:0] PATTERN = 32'hA5C3_0F96
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic [WORD_W-1:0] mem_addr,
  input wire logic [3:0] wait_cycles,
  input wire logic [2:0] fail,
  output logic mem_ack,
  output logic [WORD_W-1:0] mem_rdata,
  output logic mem_tlb_miss,
  output logic mem_zone_deny,
  output logic mem_bus_err
);
  logic [3:0] wait_cnt;
  logic answer;

  // ==========================================================
  // Answer after the programmed wait; one pulse per access.
  assign answer = mem_req && !mem_ack && (wait_cnt == wait_cycles);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      mem_ack <= 1'h0;
    end else begin
      mem_ack <= answer;
      wait_cnt <= (mem_req && !mem_ack && !answer) ? wait_cnt + 4'h1 : 4'h0;
    end
  end

  // Outside the answer cycle every line flips, so stale values never match.
  // The bus error flag stands for a failed line fill of a cachable miss.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata <= 32'h0000_0000;
      {mem_tlb_miss, mem_zone_deny, mem_bus_err} <= 3'h0;
    end else if (answer) begin
      mem_rdata <= mem_addr ^ PATTERN;
      {mem_tlb_miss, mem_zone_deny, mem_bus_err} <= fail;
    end else begin
      mem_rdata <= ~mem_rdata;
      {mem_tlb_miss, mem_zone_deny, mem_bus_err} <=
        ~{mem_tlb_miss, mem_zone_deny, mem_bus_err};
    end
  end
endmodule

// ==== tb_word_load_instruction_exec.sv ====
// Purpose: Self-checking bench of the word-load execute block.
// Assumes: Register file is modelled by fixed functions of the select.
// Notes: Each scenario issues one or more loads and judges the outputs.
`timescale 1ns/1ps
module tb_word_load_instruction_exec
  import wlie_pkg::*;
;
  localparam logic [WORD_W-1:0] PAT = 32'hA5C3_0F96;
  logic clock, rst_b, instr_valid, instr_ready, user_mode, data_xlate_en;
  logic reservation_clear, mem_req, mem_ack, mem_tlb_miss, mem_zone_deny;
  logic mem_bus_err, dest_we, base_we, reservation, string_drop_base;
  logic exc_align, exc_storage, exc_tlb_miss, exc_mcheck, done;
  logic [WORD_W-1:0] instr, base_value, index_value, mem_addr, mem_rdata;
  logic [WORD_W-1:0] dest_data, base_data;
  logic [SEL_W-1:0] base_read_sel, index_read_sel, dest_sel, base_sel;
  logic [TBC_W-1:0] string_byte_count;
  logic [3:0] wait_cycles;
  logic [2:0] fail;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  wlie_exec u_wlie_exec (
    .clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready),
    .base_read_sel(base_read_sel), .index_read_sel(index_read_sel),
    .base_value(base_value), .index_value(index_value),
    .string_byte_count(string_byte_count), .user_mode(user_mode),
    .data_xlate_en(data_xlate_en), .reservation_clear(reservation_clear),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_tlb_miss(mem_tlb_miss),
    .mem_zone_deny(mem_zone_deny), .mem_bus_err(mem_bus_err),
    .dest_we(dest_we), .dest_sel(dest_sel), .dest_data(dest_data),
    .base_we(base_we), .base_sel(base_sel), .base_data(base_data),
    .reservation(reservation), .string_drop_base(string_drop_base),
    .exc_align(exc_align), .exc_storage(exc_storage),
    .exc_tlb_miss(exc_tlb_miss), .exc_mcheck(exc_mcheck), .done(done)
  );

  wlie_cache_model #(.PATTERN(PAT)) u_wlie_cache_model (
    .clock(clock), .rst_b(rst_b), .mem_req(mem_req), .mem_addr(mem_addr),
    .wait_cycles(wait_cycles), .fail(fail), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_tlb_miss(mem_tlb_miss),
    .mem_zone_deny(mem_zone_deny), .mem_bus_err(mem_bus_err)
  );

  // ==========================================================
  // Register file and memory contents seen by the block.
  function automatic logic [31:0] rv(input logic [4:0] s);
    return 32'h1000_0000 + {19'h0, s, 8'h00};
  endfunction
  function automatic logic [31:0] iv(input logic [4:0] s);
    return {27'h0, s} * 32'h0000_0005;
  endfunction
  function automatic logic [31:0] mw(input logic [31:0] a);
    return a ^ PAT;
  endfunction
  function automatic logic [31:0] xf(input logic [9:0] xo,
      input logic [4:0] rd, input logic [4:0] ra, input logic [4:0] rb);
    return {PRI_XFORM, rd, ra, rb, xo, 1'h0};
  endfunction
  function automatic logic [31:0] df(input logic [5:0] p,
      input logic [4:0] rd, input logic [4:0] ra, input logic [15:0] d);
    return {p, rd, ra, d};
  endfunction
  assign base_value = rv(base_read_sel);
  assign index_value = iv(index_read_sel);

  // Clock at 50 MHz.
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // ==========================================================
  // Checking and closing.
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  // Issue one instruction, then judge the access and the finishing pulses.
  task automatic do_op(input logic [31:0] i, input logic acc,
      input logic [31:0] ea, input logic dwe, input logic [31:0] ed,
      input logic bwe, input logic [3:0] exc);
    int n;
    @(posedge clock);
    instr_valid <= 1'h1;
    instr <= i;
    @(posedge clock);
    instr_valid <= 1'h0;
    #1;
    chk("mem_req", mem_req, acc);
    chk("instr_ready", instr_ready, !acc);
    if (acc) chk("mem_addr", mem_addr, ea);
    n = 0;
    while (done !== 1'h1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("done", done, 1'h1);
    chk("dest_we", dest_we, dwe);
    if (dwe) chk("dest_data", dest_data, ed);
    if (dwe) chk("dest_sel", dest_sel, i[25:21]);
    chk("base_we", base_we, bwe);
    if (bwe) chk("base_data", base_data, ea);
    if (bwe) chk("base_sel", base_sel, i[20:16]);
    chk("exceptions", {exc_align, exc_storage, exc_tlb_miss, exc_mcheck},
      exc);
  endtask

  task automatic ld(input logic [31:0] i, input logic [31:0] ea,
      input logic bwe);
    do_op(i, 1'h1, ea, 1'h1, mw(ea), bwe, 4'h0);
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_plain();
    ld(df(PRI_LOAD, 5'h03, 5'h05, 16'hFFF8), rv(5'h05) - 32'h8,
      1'h0);
    ld(df(PRI_LOAD, 5'h07, 5'h00, 16'h0100), 32'h0000_0100, 1'h0);
    ld(xf(XO_INDEXED, 5'h02, 5'h00, 5'h09), iv(5'h09), 1'h0);
    ld(xf(XO_INDEXED, 5'h02, 5'h0B, 5'h01), rv(5'h0B) + 32'h5,
      1'h0);
    // A neighbouring extended opcode is not a load: done only, no access.
    do_op(xf(10'h018, 5'h02, 5'h00, 5'h09), 1'h0, 32'h0, 1'h0, 32'h0,
      1'h0, 4'h0);
  endtask

  task automatic t_update();
    ld(df(PRI_LOAD_UPD, 5'h04, 5'h00, 16'h0010), rv(5'h00) + 32'h10,
      1'h1);
    ld(df(PRI_LOAD_UPD, 5'h06, 5'h07, 16'hFFFC), rv(5'h07) - 32'h4,
      1'h1);
    ld(xf(XO_INDEXED_UPD, 5'h01, 5'h08, 5'h03), rv(5'h08) + 32'hF,
      1'h1);
    ld(xf(XO_INDEXED_UPD, 5'h05, 5'h05, 5'h03), rv(5'h05) + 32'hF,
      1'h1);
  endtask

  // Byte 0 at the lowest address lands in the least significant byte.
  task automatic t_byte_rev();
    logic [31:0] w;
    w = mw(rv(5'h02) + 32'h14);
    do_op(xf(XO_BYTE_REV, 5'h0A, 5'h02, 5'h04), 1'h1, rv(5'h02) + 32'h14,
      1'h1, {w[7:0], w[15:8], w[23:16], w[31:24]},
      1'h0, 4'h0);
  endtask

  // The clear input stands in for the conditional store of a retry loop.
  task automatic t_reserve();
    chk("reservation", reservation, 1'h0);
    do_op(xf(XO_RESERVE, 5'h0C, 5'h00, 5'h01), 1'h0, 32'h5, 1'h0, 32'h0,
      1'h0, 4'h8);
    do_op(xf(XO_RESERVE, 5'h0C, 5'h00, 5'h02), 1'h0, 32'hA, 1'h0, 32'h0,
      1'h0, 4'h8);
    chk("reservation", reservation, 1'h0);
    ld(xf(XO_RESERVE, 5'h0C, 5'h04, 5'h04), rv(5'h04) + 32'h14,
      1'h0);
    chk("reservation", reservation, 1'h1);
    @(posedge clock);
    reservation_clear <= 1'h1;
    @(posedge clock);
    reservation_clear <= 1'h0;
    #1;
    chk("reservation", reservation, 1'h0);
  endtask

  // Mode bits and cache fault flags: {user, xlate, tlb, zone, bus}.
  task automatic flt(input logic [4:0] c, input logic [3:0] exc);
    @(posedge clock);
    {user_mode, data_xlate_en, fail} <= c;
    wait_cycles <= wait_cycles + 4'h1;
    do_op(df(PRI_LOAD, 5'h03, 5'h05, 16'h0020), 1'h1, rv(5'h05) + 32'h20,
      exc == 4'h0, mw(rv(5'h05) + 32'h20), 1'h0, exc);
  endtask

  task automatic t_faults();
    flt(5'h1F, 4'h2);
    flt(5'h0C, 4'h2);
    flt(5'h16, 4'h0);
    flt(5'h1B, 4'h4);
    flt(5'h0A, 4'h0);
    flt(5'h01, 4'h1);
  endtask

  // String load: one access, no writes, drop flag judged after done.
  task automatic str(input logic [6:0] cnt, input logic [4:0] c,
      input logic [4:0] rd, input logic [4:0] ra, input logic [3:0] exc,
      input logic drop);
    @(posedge clock);
    string_byte_count <= cnt;
    {user_mode, data_xlate_en, fail} <= c;
    do_op(xf(XO_STRING, rd, ra, 5'h02), 1'h1,
      ((ra == 5'h00) ? 32'h0 : rv(ra)) + 32'hA, 1'h0, 32'h0, 1'h0, exc);
    chk("string_drop_base", string_drop_base, drop);
  endtask

  task automatic t_string();
    str(7'h00, 5'h1E, 5'h03, 5'h04, 4'h0, 1'h0);
    str(7'h00, 5'h19, 5'h03, 5'h04, 4'h1, 1'h0);
    str(7'h08, 5'h1C, 5'h03, 5'h04, 4'h2, 1'h1);
    str(7'h08, 5'h00, 5'h03, 5'h09, 4'h0, 1'h0);
    str(7'h20, 5'h00, 5'h00, 5'h00, 4'h0, 1'h1);
    str(7'h7F, 5'h00, 5'h03, 5'h09, 4'h0, 1'h1);
  endtask

  task automatic t_reserved_bits();
    @(posedge clock);
    {user_mode, data_xlate_en, fail} <= 5'h00;
    ld(xf(XO_INDEXED, 5'h0E, 5'h06, 5'h04) | 32'h1, rv(5'h06) + 32'h14,
      1'h0);
    ld(xf(XO_RESERVE, 5'h0F, 5'h06, 5'h04) | 32'h1, rv(5'h06) + 32'h14,
      1'h0);
  endtask

  // Reset in the middle of a slow access drops it and clears the
  // reservation; the first load after release must run normally.
  task automatic t_mid_reset();
    @(posedge clock);
    instr_valid <= 1'h1;
    instr <= df(PRI_LOAD, 5'h03, 5'h05, 16'h0020);
    @(posedge clock);
    instr_valid <= 1'h0;
    #1;
    chk("mem_req", mem_req, 1'h1);
    chk("reservation", reservation, 1'h1);
    @(posedge clock);
    rst_b <= 1'h0;
    #1;
    chk("mem_req", mem_req, 1'h0);
    chk("reservation", reservation, 1'h0);
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    ld(df(PRI_LOAD, 5'h03, 5'h05, 16'h0020), rv(5'h05) + 32'h20,
      1'h0);
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    rst_b = 1'h0;
    instr_valid = 1'h0;
    instr = 32'h0000_0000;
    string_byte_count = 7'h00;
    user_mode = 1'h0;
    data_xlate_en = 1'h0;
    reservation_clear = 1'h0;
    wait_cycles = 4'h0;
    fail = 3'h0;
    repeat (8) @(posedge clock);
    rst_b <= 1'h1;
    t_reserve();
    t_plain();
    t_update();
    t_byte_rev();
    t_faults();
    t_string();
    t_reserved_bits();
    t_mid_reset();
    stop_test();
  end
endmodule
